//--- shared/jcfb_defines.svh
/*
 * Constants of the character bridge: register select codes, field
 * positions inside the two bus words, and build defaults.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef JCFB_DEFINES_SVH
`define JCFB_DEFINES_SVH

// register select on the one-bit word address
`define JCFB_SEL_DATA      1'b0
`define JCFB_SEL_CTRL      1'b1

// data word fields
`define JCFB_DATA_CHAR_LSB 0
`define JCFB_DATA_VALID    15
`define JCFB_DATA_AVAIL_LSB 16

// control word fields
`define JCFB_CTRL_RIE      0
`define JCFB_CTRL_WIE      1
`define JCFB_CTRL_RIP      8
`define JCFB_CTRL_WIP      9
`define JCFB_CTRL_SPACE_LSB 16

// build defaults and limits
`define JCFB_DEPTH_DEF     64
`define JCFB_DEPTH_MIN     8
`define JCFB_DEPTH_MAX     32768
`define JCFB_THRESH_DEF    8

`endif

//--- shared/jcfb_pkg.sv
/*
 * Types shared by the character bridge files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package jcfb_pkg;
	typedef logic [7:0]  jcfb_char_t;   // one character
	typedef logic [15:0] jcfb_count_t;  // fill or space count on the bus
	typedef logic [31:0] jcfb_word_t;   // one bus word
endpackage

//--- core/jcfb_fifo.sv
/*
 * Character FIFO with a registered head word, built either from a
 * register array or from a plain memory array.
 * Assumes one clock, asynchronous active-high reset, DEPTH a power of two.
 */
`timescale 1ns/1ns
`default_nettype none
module jcfb_fifo #(
	parameter int WIDTH    = 8,   // word width
	parameter int DEPTH    = 64,  // entries, power of two
	parameter bit USE_REGS = 1'b0 // 1: flip-flops, 0: memory array
) (
	input  wire logic               clk_i,      // system clock
	input  wire logic               rst_i,      // async reset, high
	input  wire logic               wr_valid_i, // push request
	input  wire logic [WIDTH-1:0]   wr_data_i,  // pushed word
	output logic                    wr_ready_o, // not full
	output logic                    rd_valid_o, // not empty
	input  wire logic               rd_ready_i, // pop request
	output logic [WIDTH-1:0]        rd_data_o,  // head word, registered
	output logic [$clog2(DEPTH):0]  count_o     // words held
);
	localparam int AW = $clog2(DEPTH);

	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW-1:0]    rd_ptr_next;
	logic [AW:0]      count_reg;
	logic [WIDTH-1:0] rd_data_reg;
	logic [WIDTH-1:0] store [DEPTH];
	logic             push;
	logic             pop;

	// handshakes
	assign wr_ready_o  = (count_reg != (AW+1)'(DEPTH));
	assign rd_valid_o  = (count_reg != '0);
	assign push        = wr_valid_i && wr_ready_o;
	assign pop         = rd_ready_i && rd_valid_o;
	assign rd_ptr_next = pop ? rd_ptr_reg + AW'(1) : rd_ptr_reg;
	assign rd_data_o   = rd_data_reg;
	assign count_o     = count_reg;

	// storage choice; held words read the same either way, but only the register cells reset to zero
	generate
		if (USE_REGS) begin : g_regs
			for (genvar i = 0; i < DEPTH; i++) begin : g_cell
				always_ff @(posedge clk_i or posedge rst_i) begin
					if (rst_i) begin
						store[i] <= '0;
					end else if (push && wr_ptr_reg == AW'(i)) begin
						store[i] <= wr_data_i;
					end
				end
			end
		end else begin : g_mem
			always_ff @(posedge clk_i) begin
				if (push) begin
					store[wr_ptr_reg] <= wr_data_i;
				end
			end
		end
	endgenerate

	// head register, bypassing a word written into an emptied slot
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_reg <= '0;
		end else if (push && wr_ptr_reg == rd_ptr_next) begin
			rd_data_reg <= wr_data_i;
		end else begin
			rd_data_reg <= store[rd_ptr_next];
		end
	end

	// pointers and fill count
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			rd_ptr_reg <= rd_ptr_next;
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + AW'(1);
			end
			if (push && !pop) begin
				count_reg <= count_reg + (AW+1)'(1);
			end else if (pop && !push) begin
				count_reg <= count_reg - (AW+1)'(1);
			end
		end
	end
endmodule // jcfb_fifo
`default_nettype wire

//--- core/jcfb_bridge.sv
/*
 * Character bridge between a memory-mapped slave port and the scan-chain
 * side, with one FIFO per direction and a level interrupt.
 * Assumes a single bus master and a hub that feeds the scan-side ports.
 */
`timescale 1ns/1ns
`default_nettype none
`include "jcfb_defines.svh"
module jcfb_bridge #(
	parameter int WR_DEPTH  = `JCFB_DEPTH_DEF,  // write FIFO entries
	parameter int RD_DEPTH  = `JCFB_DEPTH_DEF,  // read FIFO entries
	parameter int WR_THRESH = `JCFB_THRESH_DEF, // write fill threshold
	parameter int RD_THRESH = `JCFB_THRESH_DEF, // read space threshold
	parameter bit USE_REGS  = 1'b0              // FIFOs in flip-flops
) (
	input  wire logic               clk_i,           // system clock
	input  wire logic               rst_i,           // async reset, high
	input  wire logic               bus_addr_i,      // 0 data, 1 control
	input  wire logic               bus_read_i,      // read strobe
	input  wire logic               bus_write_i,     // write strobe
	input  wire jcfb_pkg::jcfb_word_t bus_wdata_i,   // write data
	output jcfb_pkg::jcfb_word_t    bus_rdata_o,     // read data, next cycle
	output logic                    irq_o,           // interrupt, high
	input  wire logic               scan_rx_valid_i, // host char offered
	input  wire jcfb_pkg::jcfb_char_t scan_rx_data_i,// host char
	output logic                    scan_rx_ready_o, // read FIFO has room
	output logic                    scan_tx_valid_o, // char for host
	output jcfb_pkg::jcfb_char_t    scan_tx_data_o,  // char for host
	input  wire logic               scan_tx_ready_i  // host takes char
);
	localparam int WAW = $clog2(WR_DEPTH);
	localparam int RAW = $clog2(RD_DEPTH);

	logic                 wr_push;
	logic                 wr_ready;
	logic [WAW:0]         wr_count;
	logic                 rd_pop;
	logic                 rd_valid;
	jcfb_pkg::jcfb_char_t rd_char;
	logic [RAW:0]         rd_count;
	logic [RAW:0]         rd_space;
	logic [WAW:0]         wr_space;
	logic                 rie_reg;
	logic                 wie_reg;
	logic                 rip;
	logic                 wip;
	logic                 irq_reg;
	jcfb_pkg::jcfb_word_t rdata_reg;
	jcfb_pkg::jcfb_word_t rdata_next;

	// data accesses move characters through the FIFOs
	assign wr_push  = bus_write_i && bus_addr_i == `JCFB_SEL_DATA;
	assign rd_pop   = bus_read_i && bus_addr_i == `JCFB_SEL_DATA;
	assign rd_space = (RAW+1)'(RD_DEPTH) - rd_count;
	assign wr_space = (WAW+1)'(WR_DEPTH) - wr_count;

	// bus to host direction
	jcfb_fifo #(
		.WIDTH    (8),
		.DEPTH    (WR_DEPTH),
		.USE_REGS (USE_REGS)
	) u_wr_fifo (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.wr_valid_i (wr_push),
		.wr_data_i  (bus_wdata_i[`JCFB_DATA_CHAR_LSB +: 8]),
		.wr_ready_o (wr_ready),
		.rd_valid_o (scan_tx_valid_o),
		.rd_ready_i (scan_tx_ready_i),
		.rd_data_o  (scan_tx_data_o),
		.count_o    (wr_count)
	);

	// host to bus direction
	jcfb_fifo #(
		.WIDTH    (8),
		.DEPTH    (RD_DEPTH),
		.USE_REGS (USE_REGS)
	) u_rd_fifo (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.wr_valid_i (scan_rx_valid_i),
		.wr_data_i  (scan_rx_data_i),
		.wr_ready_o (scan_rx_ready_o),
		.rd_valid_o (rd_valid),
		.rd_ready_i (rd_pop),
		.rd_data_o  (rd_char),
		.count_o    (rd_count)
	);

	// control register: interrupt enables
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rie_reg <= 1'b0;
			wie_reg <= 1'b0;
		end else if (bus_write_i && bus_addr_i == `JCFB_SEL_CTRL) begin
			rie_reg <= bus_wdata_i[`JCFB_CTRL_RIE];
			wie_reg <= bus_wdata_i[`JCFB_CTRL_WIE];
		end
	end

	// pending conditions follow the FIFO levels
	assign wip = wie_reg && (wr_count <= (WAW+1)'(WR_THRESH));
	assign rip = rie_reg && rd_valid
		&& (rd_space <= (RAW+1)'(RD_THRESH));

	// interrupt line, registered
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= rip || wip;
		end
	end
	assign irq_o = irq_reg;

	// read word assembly
	always_comb begin
		rdata_next = '0;
		if (bus_addr_i == `JCFB_SEL_DATA) begin
			rdata_next[`JCFB_DATA_CHAR_LSB +: 8] = rd_valid ? rd_char : 8'h00;
			rdata_next[`JCFB_DATA_VALID]          = rd_valid;
			rdata_next[`JCFB_DATA_AVAIL_LSB +: 16] = 16'(rd_count);
		end else begin
			rdata_next[`JCFB_CTRL_RIE]            = rie_reg;
			rdata_next[`JCFB_CTRL_WIE]            = wie_reg;
			rdata_next[`JCFB_CTRL_RIP]            = rip;
			rdata_next[`JCFB_CTRL_WIP]            = wip;
			rdata_next[`JCFB_CTRL_SPACE_LSB +: 16] = 16'(wr_space);
		end
	end

	// read data register, valid the cycle after the strobe
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= '0;
		end else if (bus_read_i) begin
			rdata_reg <= rdata_next;
		end
	end
	assign bus_rdata_o = rdata_reg;

	// checks
	sequence s_data_read;
		bus_read_i && bus_addr_i == `JCFB_SEL_DATA;
	endsequence

	sequence s_data_write_room;
		bus_write_i && bus_addr_i == `JCFB_SEL_DATA && wr_ready;
	endsequence

	chk_wr_depth_legal: assert property (@(posedge clk_i) disable iff (rst_i)
		WR_DEPTH >= `JCFB_DEPTH_MIN && WR_DEPTH <= `JCFB_DEPTH_MAX
		&& (WR_DEPTH & (WR_DEPTH - 1)) == 0)
		else $error("write depth not a legal power of two");

	chk_rd_depth_legal: assert property (@(posedge clk_i) disable iff (rst_i)
		RD_DEPTH >= `JCFB_DEPTH_MIN && RD_DEPTH <= `JCFB_DEPTH_MAX
		&& (RD_DEPTH & (RD_DEPTH - 1)) == 0)
		else $error("read depth not a legal power of two");

	chk_push_counts: assert property (@(posedge clk_i) disable iff (rst_i)
		s_data_write_room and (!(scan_tx_valid_o && scan_tx_ready_i))
		|=> wr_count == $past(wr_count) + 1'b1)
		else $error("data write did not add one character");

	chk_pop_counts: assert property (@(posedge clk_i) disable iff (rst_i)
		s_data_read and (rd_valid && !(scan_rx_valid_i && scan_rx_ready_o))
		|=> rd_count == $past(rd_count) - 1'b1)
		else $error("data read did not remove one character");

	chk_read_char: assert property (@(posedge clk_i) disable iff (rst_i)
		s_data_read |=> bus_rdata_o[`JCFB_DATA_CHAR_LSB +: 8]
		== ($past(rd_valid) ? $past(rd_char) : 8'h00)
		&& bus_rdata_o[`JCFB_DATA_VALID] == $past(rd_valid))
		else $error("data read returned the wrong character");

	chk_ctrl_enables: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_write_i && bus_addr_i == `JCFB_SEL_CTRL
		##1 bus_read_i && bus_addr_i == `JCFB_SEL_CTRL
		|=> bus_rdata_o[`JCFB_CTRL_RIE] == $past(bus_wdata_i[`JCFB_CTRL_RIE], 2)
		&& bus_rdata_o[`JCFB_CTRL_WIE] == $past(bus_wdata_i[`JCFB_CTRL_WIE], 2))
		else $error("control enables not read back");

	chk_wr_thresh_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		wie_reg && wr_count <= (WAW+1)'(WR_THRESH) |=> irq_o)
		else $error("write threshold did not raise interrupt");

	chk_rd_thresh_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		rie_reg && rd_valid && rd_space <= (RAW+1)'(RD_THRESH) |=> irq_o)
		else $error("read threshold did not raise interrupt");

	chk_irq_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		!rie_reg && !wie_reg ##1 !rie_reg && !wie_reg |-> !irq_o)
		else $error("interrupt without an enabled cause");

	chk_fifo_bounds: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_count <= (WAW+1)'(WR_DEPTH) && rd_count <= (RAW+1)'(RD_DEPTH)
		&& (scan_rx_ready_o == (rd_count != (RAW+1)'(RD_DEPTH))))
		else $error("FIFO count out of range");

	// a write into a full FIFO is dropped and, while the host takes nothing, leaves it full
	chk_full_write_drop: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_write_i && bus_addr_i == `JCFB_SEL_DATA && !wr_ready && !scan_tx_ready_i
		|=> wr_count == (WAW+1)'(WR_DEPTH))
		else $error("write into a full FIFO was not dropped");

	// the line falls once no enabled cause is left
	chk_irq_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		!(rip || wip) |=> !irq_o)
		else $error("interrupt stayed without a cause");
endmodule // jcfb_bridge
`default_nettype wire

//--- tb/jcfb_host_model.sv
/*
 * Scan-side host model: offers queued characters to the read FIFO and
 * takes characters from the write FIFO with random stalls.
 * Assumes one clock shared with the bridge and a seeded $urandom.
 */
`timescale 1ns/1ns
`default_nettype none
module jcfb_host_model (
	input  wire logic            clk_i,      // system clock
	input  wire logic            hold_i,     // stop taking characters
	output logic                 rx_valid_o, // character offered
	output jcfb_pkg::jcfb_char_t rx_data_o,  // offered character
	input  wire logic            rx_ready_i, // read FIFO has room
	output logic                 tx_ready_o  // host takes character
);
	jcfb_pkg::jcfb_char_t rx_q[$];
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o  = 8'h00;
		tx_ready_o = 1'b0;
	end
	// stands in for the hub that joins the bridge to the scan controller
	// offer in order, scramble the idle line so stale data never looks valid
	always @(posedge clk_i) begin
		if (rx_valid_o && rx_ready_i)
			void'(rx_q.pop_front());
		rx_valid_o <= rx_q.size() > 0;
		rx_data_o  <= (rx_q.size() > 0) ? rx_q[0] : ~rx_data_o;
		tx_ready_o <= !hold_i && ($urandom_range(0, 3) != 0); // ready about three cycles in four
	end
endmodule // jcfb_host_model
`default_nettype wire

//--- tb/jcfb_bridge_tb.sv
/*
 * Self-checking bench of the character bridge: the read task and the test note expected
 * results in queues, watchers compare them when results appear.
 * Assumes small depths so that full and threshold cases are quick.
 */
`timescale 1ns/1ns
`default_nettype none
module jcfb_bridge_tb;
	localparam int DEP = 8;
	localparam int THR = 2;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic bus_addr_i = 1'b0;
	logic bus_read_i = 1'b0;
	logic bus_write_i = 1'b0;
	jcfb_pkg::jcfb_word_t bus_wdata_i = 32'h0;
	jcfb_pkg::jcfb_word_t bus_rdata_o;
	logic irq_o, rx_valid, rx_ready, tx_valid, tx_ready, hold = 1'b0;
	jcfb_pkg::jcfb_char_t rx_data, tx_data, c;
	jcfb_pkg::jcfb_word_t exp_rd[$];
	jcfb_pkg::jcfb_char_t exp_tx[$], sent[$];
	int fails = 0;
	int total_checks = 0;

	jcfb_bridge #(.WR_DEPTH(DEP), .RD_DEPTH(DEP), .WR_THRESH(THR), .RD_THRESH(THR),
		.USE_REGS(1'b1)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i),
		.bus_read_i(bus_read_i), .bus_write_i(bus_write_i), .bus_wdata_i(bus_wdata_i),
		.bus_rdata_o(bus_rdata_o), .irq_o(irq_o), .scan_rx_valid_i(rx_valid),
		.scan_rx_data_i(rx_data), .scan_rx_ready_o(rx_ready), .scan_tx_valid_o(tx_valid),
		.scan_tx_data_o(tx_data), .scan_tx_ready_i(tx_ready));
	jcfb_host_model i_host (.clk_i(clk_i), .hold_i(hold), .rx_valid_o(rx_valid),
		.rx_data_o(rx_data), .rx_ready_i(rx_ready), .tx_ready_o(tx_ready));

	// memory build on the same stimulus, must match the register build
	jcfb_pkg::jcfb_word_t m_rdata;
	jcfb_pkg::jcfb_char_t m_tx_data;
	logic m_irq, m_rx_ready, m_tx_valid;
	jcfb_bridge #(.WR_DEPTH(DEP), .RD_DEPTH(DEP), .WR_THRESH(THR), .RD_THRESH(THR),
		.USE_REGS(1'b0)) i_dut_mem (.clk_i(clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i),
		.bus_read_i(bus_read_i), .bus_write_i(bus_write_i), .bus_wdata_i(bus_wdata_i),
		.bus_rdata_o(m_rdata), .irq_o(m_irq), .scan_rx_valid_i(rx_valid),
		.scan_rx_data_i(rx_data), .scan_rx_ready_o(m_rx_ready), .scan_tx_valid_o(m_tx_valid),
		.scan_tx_data_o(m_tx_data), .scan_tx_ready_i(tx_ready));

	// 50 MHz clock
	always #10 clk_i = ~clk_i;

	task automatic check(input jcfb_pkg::jcfb_word_t seen, input jcfb_pkg::jcfb_word_t exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// the bench is the only bus master of the bridge
	task automatic bus_wr(input logic a, input jcfb_pkg::jcfb_word_t d);
		@(posedge clk_i);
		bus_addr_i  <= a;
		bus_wdata_i <= d;
		bus_write_i <= 1'b1;
		@(posedge clk_i);
		bus_write_i <= 1'b0;
	endtask

	task automatic bus_rd(input logic a, input jcfb_pkg::jcfb_word_t e);
		@(posedge clk_i);
		exp_rd.push_back(e);
		bus_addr_i <= a;
		bus_read_i <= 1'b1;
		@(posedge clk_i);
		bus_read_i <= 1'b0;
	endtask

	task automatic drain;
		for (int i = 0; i < 300 && tx_valid !== 1'b0; i++)
			@(posedge clk_i);
		repeat (3) @(posedge clk_i);
	endtask

	// read word is due just after the taking edge
	always @(posedge clk_i)
		if (bus_read_i === 1'b1) begin
			#1 check(bus_rdata_o, exp_rd.pop_front());
		end

	// characters reach the host whole and in order
	always @(posedge clk_i)
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			check({24'h0, tx_data}, {24'h0, exp_tx.pop_front()});

	// both storage builds show the same outputs once settled
	always @(negedge clk_i)
		if (rst_i === 1'b0) begin
			check(m_rdata, bus_rdata_o);
			check({31'h0, m_irq}, {31'h0, irq_o});
			check({30'h0, m_rx_ready, m_tx_valid}, {30'h0, rx_ready, tx_valid});
			if (tx_valid === 1'b1)
				check({24'h0, m_tx_data}, {24'h0, tx_data});
		end

	// watchdog
	initial begin
		#400000;
		fails++;
		stop_test();
	end

	initial begin
		void'($urandom(39081));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check({29'h0, irq_o, rx_ready, tx_valid}, 32'h2);
		check(bus_rdata_o, 32'h0);
		// stream out with host stalls
		for (int i = 0; i < 8; i++) begin
			c = 8'($urandom);
			exp_tx.push_back(c);
			bus_wr(1'b0, {24'h0, c});
		end
		drain();
		// fill write FIFO until refused while host holds off
		hold <= 1'b1;
		bus_wr(1'b1, 32'h2);
		for (int i = 0; i <= DEP; i++) begin
			c = 8'($urandom);
			if (i < DEP)
				exp_tx.push_back(c);
			bus_wr(1'b0, {24'h0, c});
		end
		bus_rd(1'b1, 32'h0000_0002);
		check({31'h0, irq_o}, 32'h0);
		hold <= 1'b0;
		drain();
		check({31'h0, irq_o}, 32'h1);
		bus_rd(1'b1, 32'h0008_0202);
		// read FIFO filled to its space threshold, then emptied
		// control write with its read-back in the very next cycle
		@(posedge clk_i);
		bus_addr_i  <= 1'b1;
		bus_wdata_i <= 32'h1;
		bus_write_i <= 1'b1;
		@(posedge clk_i);
		exp_rd.push_back(32'h0008_0001);
		bus_write_i <= 1'b0;
		bus_read_i  <= 1'b1;
		@(posedge clk_i);
		bus_read_i  <= 1'b0;
		for (int i = 0; i < DEP - THR; i++) begin
			c = 8'($urandom);
			sent.push_back(c);
			i_host.rx_q.push_back(c);
		end
		repeat (20) @(posedge clk_i);
		check({31'h0, irq_o}, 32'h1);
		bus_rd(1'b1, 32'h0008_0101);
		for (int i = 0; i < DEP - THR; i++)
			bus_rd(1'b0, {16'(DEP - THR - i), 8'h80, sent[i]});
		bus_rd(1'b0, 32'h0);
		check({31'h0, irq_o}, 32'h0);
		// fill read FIFO until the host is refused
		for (int i = 0; i < DEP + 2; i++)
			i_host.rx_q.push_back(8'(i));
		repeat (30) @(posedge clk_i);
		check({31'h0, rx_ready}, 32'h0);
		// each early pop lets one waiting host char in, so the count stays full twice
		for (int i = 0; i < DEP + 2; i++)
			bus_rd(1'b0, {16'((i < 2) ? DEP : DEP + 2 - i), 8'h80, 8'(i)});
		repeat (10) @(posedge clk_i);
		check({31'h0, rx_valid}, 32'h0);
		stop_test();
	end
endmodule // jcfb_bridge_tb
`default_nettype wire
